// file: core/alarm_cmp_if.sv
// Carrier between the register block and the alarm comparator
`timescale 1ns/1ps
interface alarm_cmp_if;
  logic [31:0] alarm_value;
  logic [31:0] calendar;
  logic [2:0] depth;
  logic match;

  modport ctrl (
    output alarm_value,
    output calendar,
    output depth,
    input match
  );

  modport cmp (
    input alarm_value,
    input calendar,
    input depth,
    output match
  );
endinterface

// file: core/alarm_field_compare.sv
// Depth-masked comparison of alarm value against the running calendar
`timescale 1ns/1ps
module alarm_field_compare
  import cal_alarm_pkg::*;
(
  alarm_cmp_if.cmp bus
);

  wire [31:0] field_mask;
  wire [31:0] diff;
  wire depth_valid;

  // Seconds always join once enabled; each higher field needs a deeper select
  assign field_mask[second_msb:second_lsb] = {6{bus.depth > 3'h0}};
  assign field_mask[minute_msb:minute_lsb] = {6{bus.depth > 3'h1}};
  assign field_mask[hour_msb:hour_lsb] = {5{bus.depth > 3'h2}};
  assign field_mask[day_msb:day_lsb] = {5{bus.depth > 3'h3}};
  assign field_mask[month_msb:month_lsb] = {4{bus.depth > 3'h4}};
  assign field_mask[year_msb:year_lsb] = {6{bus.depth == depth_full}};

  // Off and the reserved code never match
  assign depth_valid = (bus.depth != depth_off) && (bus.depth != depth_reserved);
  assign diff = (bus.alarm_value ^ bus.calendar) & field_mask;
  assign bus.match = depth_valid && (diff == 32'h0000_0000);

endmodule

// file: core/cal_alarm_pkg.sv
// Shared constants and types for the calendar alarm comparator
package cal_alarm_pkg;

  localparam int unsigned data_w = 32;
  localparam int unsigned addr_w = 8;

  // Register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] calendar_off = 8'h04;
  localparam logic [7:0] interrupt_flag_off = 8'h08;
  localparam logic [7:0] event_status_off = 8'h10;
  localparam logic [7:0] event_mask_off = 8'h14;
  localparam logic [7:0] calendar_alarm_value_off = 8'h18;
  localparam logic [7:0] alarm_match_depth_select_off = 8'h1c;

  // Reset values
  localparam logic [31:0] calendar_alarm_value_rst = 32'h0000_0000;
  localparam logic [7:0] alarm_match_depth_select_rst = 8'h00;
  localparam logic [31:0] calendar_rst = 32'h0000_0000;
  localparam logic [2:0] ctrl_rst = 3'h0;
  localparam logic [1:0] event_mask_rst = 2'h0;

  // Control register bits
  localparam int unsigned ctrl_enable_bit = 0;
  localparam int unsigned ctrl_clear_on_match_bit = 1;
  localparam int unsigned ctrl_twelve_hour_bit = 2;

  // Event bits, shared by status, mask and interrupt flag layouts
  localparam int unsigned ev_alarm_bit = 0;
  localparam int unsigned ev_year_wrap_bit = 1;
  localparam int unsigned ev_w = 2;

  // Calendar field positions
  localparam int unsigned year_lsb = 26;
  localparam int unsigned year_msb = 31;
  localparam int unsigned month_lsb = 22;
  localparam int unsigned month_msb = 25;
  localparam int unsigned day_lsb = 17;
  localparam int unsigned day_msb = 21;
  localparam int unsigned hour_lsb = 12;
  localparam int unsigned hour_msb = 16;
  localparam int unsigned minute_lsb = 6;
  localparam int unsigned minute_msb = 11;
  localparam int unsigned second_lsb = 0;
  localparam int unsigned second_msb = 5;
  localparam int unsigned depth_lsb = 0;
  localparam int unsigned depth_msb = 2;

  // Match-depth selection codes
  typedef enum logic [2:0] {
    depth_off = 3'h0,
    depth_ss = 3'h1,
    depth_mmss = 3'h2,
    depth_hhmmss = 3'h3,
    depth_ddhhmmss = 3'h4,
    depth_mmddhhmmss = 3'h5,
    depth_full = 3'h6,
    depth_reserved = 3'h7
  } depth_t;

  // Field limits
  localparam logic [5:0] second_max = 6'h3b;
  localparam logic [5:0] minute_max = 6'h3b;
  localparam logic [4:0] hour24_max = 5'h17;
  localparam logic [3:0] hour12_max = 4'hc;
  localparam logic [3:0] hour12_turn = 4'hb;
  localparam logic [3:0] month_max = 4'hc;
  localparam logic [3:0] month_feb = 4'h2;
  localparam logic [4:0] day_first = 5'h01;
  localparam logic [3:0] month_first = 4'h1;
  localparam logic [3:0] hour12_first = 4'h1;

  // AHB-Lite encodings
  localparam logic [1:0] htrans_nonseq = 2'b10;
  localparam logic [1:0] htrans_seq = 2'b11;
  localparam logic hresp_okay = 1'b0;

endpackage

// file: core/calendar_alarm_compare.sv
// Real time calendar counter with alarm compare, AHB-Lite register slave
// Summary of operation
// - The alarm value is compared all the time with the running calendar over the enabled fields.
// - A match sets the alarm hit flag on the counter cycle after the matching one.
// - A match clears the running calendar to zero when clear-on-match is set.
// - The year field, bits 31:26, joins the compare only at match depth 6.
// - The month field, bits 25:22, joins the compare at match depth above 4.
// - The day field, bits 21:17, joins the compare at match depth above 3.
// - The hour field, bits 16:12, joins the compare at match depth above 2.
// - The minute field, bits 11:6, joins the compare at match depth above 1.
// - The second field, bits 5:0, joins the compare at match depth above 0.
// - The match depth sits in bits 2:0; zero turns the alarm off and seven is reserved.
// - Hours count 0 to 23, or 1 to 12 with bit 4 marking afternoon in twelve-hour mode.
// - Months count 1 to 12 and days run from 1 to the length of the month.
`timescale 1ns/1ps
module calendar_alarm_compare
  import cal_alarm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic count_tick,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] calendar,
  output logic alarm_hit_flag,
  output logic irq
);

  import cal_alarm_pkg::*;

  // Register state
  logic [31:0] calendar_alarm_value_reg;
  logic [7:0] alarm_match_depth_select_reg;
  logic [31:0] calendar_reg;
  logic [31:0] calendar_next;
  logic [2:0] ctrl_reg;
  logic [ev_w-1:0] interrupt_flag_reg;
  logic [ev_w-1:0] interrupt_flag_next;
  logic [ev_w-1:0] event_status_reg;
  logic [ev_w-1:0] event_status_next;
  logic [ev_w-1:0] event_mask_reg;
  logic [31:0] hrdata_reg;

  // Captured address phase
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  // Days in a month; a year is a leap year when its two low bits are zero
  function automatic logic [4:0] month_days(input logic [3:0] month, input logic [5:0] year);
    logic [4:0] days;
    days = 5'h1f;
    if (month == month_feb) begin
      days = (year[1:0] == 2'b00) ? 5'h1d : 5'h1c;
    end else if (month == 4'h4 || month == 4'h6 || month == 4'h9 || month == 4'hb) begin
      days = 5'h1e;
    end
    return days;
  endfunction

  // One second step of the packed calendar, with carry into every field
  function automatic logic [31:0] calendar_step(input logic [31:0] cur, input logic h12);
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [4:0] day;
    logic [3:0] mon;
    logic [5:0] yr;
    logic carry;
    sec = cur[second_msb:second_lsb];
    min = cur[minute_msb:minute_lsb];
    hour = cur[hour_msb:hour_lsb];
    day = cur[day_msb:day_lsb];
    mon = cur[month_msb:month_lsb];
    yr = cur[year_msb:year_lsb];
    carry = 1'b0;
    if (sec >= second_max) begin
      sec = 6'h00;
      carry = 1'b1;
    end else begin
      sec = sec + 6'h01;
    end
    if (carry) begin
      carry = 1'b0;
      if (min >= minute_max) begin
        min = 6'h00;
        carry = 1'b1;
      end else begin
        min = min + 6'h01;
      end
    end
    if (carry) begin
      carry = 1'b0;
      if (h12) begin
        // 11 AM goes to 12 PM, 11 PM goes to 12 AM of the next day
        if (hour[3:0] == hour12_turn) begin
          carry = hour[4];
          hour = {~hour[4], hour12_max};
        end else if (hour[3:0] >= hour12_max) begin
          hour = {hour[4], hour12_first};
        end else begin
          hour = {hour[4], hour[3:0] + 4'h1};
        end
      end else if (hour >= hour24_max) begin
        hour = 5'h00;
        carry = 1'b1;
      end else begin
        hour = hour + 5'h01;
      end
    end
    if (carry) begin
      carry = 1'b0;
      if (day >= month_days(mon, yr)) begin
        day = day_first;
        carry = 1'b1;
      end else begin
        day = day + 5'h01;
      end
    end
    if (carry) begin
      carry = 1'b0;
      if (mon >= month_max) begin
        mon = month_first;
        carry = 1'b1;
      end else begin
        mon = mon + 4'h1;
      end
    end
    if (carry) begin
      yr = yr + 6'h01;
    end
    return {yr, mon, day, hour, min, sec};
  endfunction

  // Comparator hookup
  alarm_cmp_if cmp_bus ();

  assign cmp_bus.alarm_value = calendar_alarm_value_reg;
  assign cmp_bus.calendar = calendar_reg;
  assign cmp_bus.depth = alarm_match_depth_select_reg[depth_msb:depth_lsb];

  alarm_field_compare u_compare (
    .bus(cmp_bus.cmp)
  );

  // Bus decode
  wire addr_phase = hsel && hready && htrans[1] && ce;
  wire rd_take = addr_phase && !hwrite;
  wire wr_take = addr_phase && hwrite;
  wire [7:0] rd_addr = haddr[7:0];
  wire wr_now = wr_pend_reg && ce;

  wire wr_ctrl = wr_now && (wr_addr_reg == ctrl_off);
  wire wr_calendar = wr_now && (wr_addr_reg == calendar_off);
  wire wr_flag = wr_now && (wr_addr_reg == interrupt_flag_off);
  wire wr_mask = wr_now && (wr_addr_reg == event_mask_off);
  wire wr_alarm = wr_now && (wr_addr_reg == calendar_alarm_value_off);
  wire wr_depth = wr_now && (wr_addr_reg == alarm_match_depth_select_off);
  wire rd_status = rd_take && (rd_addr == event_status_off);

  // Counter behaviour
  wire count_enabled = ctrl_reg[ctrl_enable_bit];
  wire step = ce && count_tick && count_enabled;
  wire alarm_match = cmp_bus.match;
  wire [31:0] calendar_stepped = calendar_step(calendar_reg, ctrl_reg[ctrl_twelve_hour_bit]);
  wire year_wrap = step && (calendar_stepped[year_msb:year_lsb] == 6'h00)
                   && (calendar_reg[year_msb:year_lsb] != 6'h00);

  // Match is sampled at the counter tick, so the flag appears in the next counter cycle
  wire alarm_event = step && alarm_match;
  wire [ev_w-1:0] events = {year_wrap, alarm_event};

  // Software write of the calendar wins over a tick in the same cycle
  always_comb begin
    calendar_next = calendar_reg;
    if (wr_calendar) begin
      calendar_next = hwdata;
    end else if (alarm_event && ctrl_reg[ctrl_clear_on_match_bit]) begin
      calendar_next = calendar_rst;
    end else if (step) begin
      calendar_next = calendar_stepped;
    end
  end

  // Write one to clear; a new event in the same cycle keeps the bit set
  always_comb begin
    interrupt_flag_next = interrupt_flag_reg;
    if (wr_flag) begin
      interrupt_flag_next = interrupt_flag_reg & ~hwdata[ev_w-1:0];
    end
    interrupt_flag_next = interrupt_flag_next | events;
  end

  // Read to clear; again the set wins
  always_comb begin
    event_status_next = rd_status ? '0 : event_status_reg;
    event_status_next = event_status_next | events;
  end

  // Read mux, latched at the address phase so data come from a flip-flop
  logic [31:0] rd_value;
  always_comb begin
    unique case (rd_addr)
      ctrl_off: rd_value = {29'h0, ctrl_reg};
      calendar_off: rd_value = calendar_reg;
      interrupt_flag_off: rd_value = {30'h0, interrupt_flag_reg};
      event_status_off: rd_value = {30'h0, event_status_reg};
      event_mask_off: rd_value = {30'h0, event_mask_reg};
      calendar_alarm_value_off: rd_value = calendar_alarm_value_reg;
      alarm_match_depth_select_off: rd_value = {24'h0, alarm_match_depth_select_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_reg <= wr_take;
      wr_addr_reg <= wr_take ? haddr[7:0] : wr_addr_reg;
      hrdata_reg <= rd_take ? rd_value : hrdata_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= ctrl_rst;
      event_mask_reg <= event_mask_rst;
      calendar_alarm_value_reg <= calendar_alarm_value_rst;
      alarm_match_depth_select_reg <= alarm_match_depth_select_rst;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[2:0];
      end
      if (wr_mask) begin
        event_mask_reg <= hwdata[ev_w-1:0];
      end
      if (wr_alarm) begin
        calendar_alarm_value_reg <= hwdata;
      end
      // Only the select bits are stored; the rest read as zero
      if (wr_depth) begin
        alarm_match_depth_select_reg <= {5'h00, hwdata[depth_msb:depth_lsb]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      calendar_reg <= calendar_rst;
      interrupt_flag_reg <= '0;
      event_status_reg <= '0;
    end else if (ce) begin
      calendar_reg <= calendar_next;
      interrupt_flag_reg <= interrupt_flag_next;
      event_status_reg <= event_status_next;
    end
  end

  // Zero wait states; while ce is low the slave stalls the bus
  assign hreadyout = ce;
  assign hresp = hresp_okay;
  assign hrdata = hrdata_reg;
  assign calendar = calendar_reg;
  assign alarm_hit_flag = interrupt_flag_reg[ev_alarm_bit];
  assign irq = |(event_status_reg & event_mask_reg);

endmodule

// file: test/calendar_alarm_compare_chk.sv
// Assertion checker on the calendar alarm comparator ports
`timescale 1ns/1ps
module calendar_alarm_compare_chk
  import cal_alarm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic count_tick,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] calendar,
  input wire logic alarm_hit_flag,
  input wire logic irq
);
  // Address phase is remembered so the data phase can be judged
  logic wr_reg;
  logic [7:0] wa_reg;
  wire logic flag_clr = wr_reg && wa_reg == interrupt_flag_off && hwdata[0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      wa_reg <= 8'h00;
    end else if (ce) begin
      wr_reg <= hsel && hready && htrans[1] && hwrite;
      wa_reg <= haddr[7:0];
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_ready: assert property (hreadyout == ce)
    else $error("hreadyout differs from ce");
  a_resp_okay: assert property (hresp == hresp_okay)
    else $error("hresp not okay");
  a_flag_cause: assert property ($rose(alarm_hit_flag) |-> $past(count_tick && ce))
    else $error("flag rose without a tick");
  a_flag_sticky: assert property (alarm_hit_flag && !flag_clr |=> alarm_hit_flag)
    else $error("flag dropped without a clear");
  a_flag_clear: assert property (flag_clr && ce && !count_tick |=> !alarm_hit_flag)
    else $error("flag not cleared by write one");
  a_cal_cause: assert property (!$stable(calendar) |-> $past(count_tick) || $past(wr_reg))
    else $error("calendar moved without tick or write");
  a_second_step: assert property (count_tick && ce && !wr_reg && calendar[5:0] < second_max
    |=> $stable(calendar) || calendar == 32'h0 || calendar[5:0] == $past(calendar[5:0]) + 6'h1
  ) else $error("calendar step wrong");
  a_ce_freeze: assert property (!ce |=> $stable(calendar) && $stable(alarm_hit_flag))
    else $error("state moved while ce low");
  a_irq_cause: assert property ($rose(irq) |-> $past(count_tick) || $past(wr_reg))
    else $error("irq rose without cause");
endmodule

bind calendar_alarm_compare calendar_alarm_compare_chk calendar_alarm_compare_chk_i (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .count_tick(count_tick), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .calendar(calendar),
  .alarm_hit_flag(alarm_hit_flag), .irq(irq)
);

// file: test/calendar_alarm_compare_tb.sv
// Self-checking bench for the calendar alarm comparator
`timescale 1ns/1ps
module calendar_alarm_compare_tb;
  import cal_alarm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic count_tick = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] calendar;
  logic alarm_hit_flag;
  logic irq;
  logic [31:0] q;
  int errors = 0;
  int n_tests = 0;
  // A valid date, so one flipped bit stays inside a single field
  localparam logic [31:0] cal = {6'h05, 4'h3, 5'h0f, 5'h0a, 6'h1e, 6'h14};
  localparam int unsigned lsb [6] = '{second_lsb, minute_lsb, hour_lsb, day_lsb,
    month_lsb, year_lsb};
  always #20 hclk = ~hclk;
  assign hready = hreadyout;
  calendar_alarm_compare calendar_alarm_compare_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .count_tick(count_tick), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .calendar(calendar), .alarm_hit_flag(alarm_hit_flag), .irq(irq)
  );
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Slave may stall via hready, so every wait is bounded
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        complete_run();
      end
      @(posedge hclk);
    end
  endtask
  // Leading edge leaves one idle cycle, so a read never meets a just-written word
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= htrans_nonseq;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic tick;
    @(posedge hclk);
    count_tick <= 1'b1;
    @(posedge hclk);
    count_tick <= 1'b0;
    @(negedge hclk);
  endtask
  task automatic run(input logic [2:0] d, input logic [31:0] al, input logic hit,
    input logic clr);
    xfer(1'b1, interrupt_flag_off, 32'h1);
    xfer(1'b1, calendar_off, cal);
    xfer(1'b1, calendar_alarm_value_off, al);
    xfer(1'b1, alarm_match_depth_select_off, {29'h0, d});
    tick();
    chk("alarm_hit_flag", {31'h0, hit}, {31'h0, alarm_hit_flag});
    chk("calendar", (hit && clr) ? 32'h0 : cal + 32'h1, calendar);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(calendar_alarm_value_off, 32'h0, "alarm value reset");
    rd(alarm_match_depth_select_off, 32'h0, "depth reset");
    xfer(1'b1, alarm_match_depth_select_off, 32'hff);
    rd(alarm_match_depth_select_off, 32'h7, "depth bits");
    xfer(1'b1, 8'h3c, 32'hffff_ffff);
    rd(8'h3c, 32'h0, "unmapped");
    $display("test registers done");
    xfer(1'b1, ctrl_off, 32'h1);
    for (int d = 0; d < 8; d++) begin
      run(d[2:0], cal ^ ((d < 6) ? 32'h1 << lsb[d] : 32'h0), d inside {[1:6]}, 1'b0);
      if (d inside {[1:6]})
        run(d[2:0], cal ^ (32'h1 << lsb[d - 1]), 1'b0, 1'b0);
    end
    rd(calendar_alarm_value_off, cal, "alarm value");
    $display("test depth done");
    xfer(1'b1, ctrl_off, 32'h3);
    run(3'h6, cal, 1'b1, 1'b1);
    tick();
    chk("sticky flag", 32'h1, {31'h0, alarm_hit_flag});
    xfer(1'b1, interrupt_flag_off, 32'h0);
    @(negedge hclk);
    chk("flag write zero", 32'h1, {31'h0, alarm_hit_flag});
    xfer(1'b1, interrupt_flag_off, 32'h1);
    @(negedge hclk);
    chk("flag write one", 32'h0, {31'h0, alarm_hit_flag});
    @(posedge hclk);
    ce <= 1'b0;
    count_tick <= 1'b1;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    count_tick <= 1'b0;
    @(negedge hclk);
    chk("frozen calendar", 32'h1, calendar);
    $display("test clear and hold done");
    xfer(1'b1, ctrl_off, 32'h1);
    xfer(1'b1, event_mask_off, 32'h1);
    rd(event_status_off, 32'h1, "status history");
    run(3'h1, cal, 1'b1, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    rd(event_status_off, 32'h1, "status");
    @(negedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    xfer(1'b1, event_mask_off, 32'h0);
    run(3'h1, cal, 1'b1, 1'b0);
    chk("masked irq", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    complete_run();
  end
endmodule
